// *** include/dma_request_recognition_defines.vh ***
// Constants for the DMA request recognition block
`ifndef DMA_REQUEST_RECOGNITION_DEFINES_VH
`define DMA_REQUEST_RECOGNITION_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define GENERAL_CONTROL_REGISTER_ADDR    6'h00
`define STATUS_REGISTER_ADDR             6'h04
`define OPERATION_CONTROL_REGISTER_ADDR  6'h10
`define TRANSFER_COUNT_REGISTER_ADDR     6'h20

// ****************************************
// Channel control register fields
// ****************************************
`define CTL_START_BIT       0
`define CTL_SRC_LSB         1
`define CTL_EXT_LSB         3
`define CTL_DTYPE_LSB       5
`define CTL_PRIO_LSB        7
`define CTL_HBYTE_BIT       9
`define CTL_DIR_BIT         10

// ****************************************
// Request generation, external mode, device type
// ****************************************
`define SRC_AUTO_LIMITED    2'h0
`define SRC_AUTO_MAX        2'h1
`define SRC_EXTERNAL        2'h2
`define SRC_MIXED           2'h3
`define EXT_BURST           2'h0
`define EXT_STEAL           2'h2
`define EXT_STEAL_HOLD      2'h3
`define DTYPE_DUAL_16       2'h0
`define DTYPE_DUAL_8        2'h1
`define DTYPE_SINGLE_ACK    2'h2
`define DTYPE_SINGLE_READY  2'h3

// ****************************************
// Sample interval exponents
// ****************************************
`define WINDOW_EXP_BASE     4'h4
`define INTERVAL_EXP_BASE   4'h5
`define RATIO_EXP_BASE      4'h1

`endif

// *** src/dma_request_recognition.v ***
// Request recognition and transfer sequencing for a four-channel DMA controller
//
// Notes on behaviour
// R01 - Transfer-complete strobe low on completed transfers and chain fetches, never on exceptions.
// R02 - Strobe goes low before data strobes rise and returns high after them.
// R03 - Mixed request generation auto-requests the first transfer, then waits for the peripheral.
// R04 - Maximum-rate auto-request always pending; bus kept until transfer completes.
// R05 - Limited rate: equal back-to-back sample intervals; decision at each interval end.
// R06 - Auto-request window lasts two to the burst-time plus four clocks.
// R07 - Sample interval lasts two to burst-time plus bandwidth-ratio plus five clocks.
// R08 - Other-master usage above the allowed ratio suppresses requests next interval.
// R09 - Active bus-grant-acknowledge counts as non-processor use, inactive as processor use.
// R10 - Higher priority channels preempt; equal priorities rotate round robin.
// R11 - Auto-request with dual 16-bit device keeps acknowledge, high byte, done inactive.
// R12 - External mode field selects burst or cycle-steal recognition.
// R13 - Burst request sampled on rising edges; peripheral holds it until cycle starts.
// R14 - Peripheral negates request one clock before strobe clock to end a burst.
// R15 - Cycle steal recognises a falling edge held low at least two clocks.
// R16 - Edge during a cycle continues without releasing bus, few idle clocks.
// R17 - No hold releases after each transfer; hold keeps bus until stop or pause.
// R18 - Under hold a new request is acknowledged within seven and a half clocks.
// R19 - Hold persists after count exhaustion; other channels still serviced.
// R20 - Dual-address cycle steal ignores requests until device transfer starts.
// R21 - Device type selects dual addressing or single addressing with acknowledge/ready.
// R22 - Dual addressing reads source into holding register then writes destination.
// R23 - Acknowledge selects the device and marks destination in memory-to-memory non-auto.
// R24 - Interval decision is held for the whole following interval.
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "dma_request_recognition_defines.vh"

module dma_request_recognition #(
  parameter CHANNELS    = 4,
  parameter COUNT_WIDTH = 16,
  parameter DATA_WIDTH  = 16
) (
  // Clock and reset
  input  wire                        clk_i,
  input  wire                        rst_i,
  // Wishbone slave
  input  wire                        wb_cyc_i,
  input  wire                        wb_stb_i,
  input  wire                        wb_we_i,
  input  wire [5:0]                  wb_adr_i,
  input  wire [3:0]                  wb_sel_i,
  input  wire [31:0]                 wb_dat_i,
  output reg  [31:0]                 wb_dat_o,
  output reg                         wb_ack_o,
  // Peripheral lines
  input  wire [CHANNELS-1:0]         request_n_i,
  input  wire [CHANNELS-1:0]         peripheral_control_line_n_i,
  output reg  [CHANNELS-1:0]         ack_n_o,
  output reg                         high_byte_indicator_n_o,
  output reg                         done_o,
  output reg                         done_oe_o,
  output reg                         transfer_complete_strobe_n_o,
  // System bus
  input  wire                        bus_grant_n_i,
  input  wire                        bus_grant_acknowledge_n_i,
  input  wire                        dtack_n_i,
  input  wire                        bus_error_n_i,
  input  wire                        chain_fetch_i,
  input  wire [DATA_WIDTH-1:0]       bus_data_i,
  output reg  [DATA_WIDTH-1:0]       bus_data_o,
  output reg                         bus_request_n_o,
  output reg                         bus_owned_o,
  output reg                         address_strobe_n_o,
  output reg                         lower_data_strobe_n_o,
  output reg                         upper_data_strobe_n_o,
  output reg                         read_not_write_o,
  output reg                         device_phase_o,
  output reg  [1:0]                  channel_o
);

  // ****************************************
  // States
  // ****************************************
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ARB  = 8'h02;
  localparam [7:0] ST_ADDR = 8'h04;
  localparam [7:0] ST_WAIT = 8'h08;
  localparam [7:0] ST_TCS  = 8'h10;
  localparam [7:0] ST_NEG  = 8'h20;
  localparam [7:0] ST_END  = 8'h40;
  localparam [7:0] ST_HOLD = 8'h80;

  // ****************************************
  // Storage
  // ****************************************
  reg  [10:0]            ctl_q [0:CHANNELS-1];
  reg  [COUNT_WIDTH-1:0] count_q [0:CHANNELS-1];
  reg  [1:0]             burst_time_field_q;
  reg  [1:0]             bandwidth_ratio_field_q;
  reg  [CHANNELS-1:0]    active_q;
  reg  [CHANNELS-1:0]    pending_q;
  reg  [CHANNELS-1:0]    first_q;
  reg  [CHANNELS-1:0]    blocked_q;
  reg  [CHANNELS-1:0]    req_d1_q;
  reg  [CHANNELS-1:0]    req_d2_q;
  reg  [CHANNELS-1:0]    wants;
  reg  [7:0]             state_q;
  reg  [7:0]             state_d;
  reg  [1:0]             cur_q;
  reg  [1:0]             rr_q;
  reg                    phase_q;
  reg                    chain_q;
  reg                    aborted_q;
  reg                    hold_q;
  reg                    hold_armed_q;
  reg                    seen_q;
  reg                    allow_q;
  reg  [10:0]            free_cnt_q;
  reg  [11:0]            busy_cnt_q;
  reg  [DATA_WIDTH-1:0]  holding_q;
  reg  [1:0]             pick;
  reg                    any_want;
  integer                i;

  wire                   wb_req      = wb_cyc_i & wb_stb_i;
  wire                   wb_write    = wb_req & wb_we_i & wb_ack_o;
  wire [3:0]             wb_index    = wb_adr_i[5:2];
  wire [3:0]             int_exp     = {2'h0, burst_time_field_q} + {2'h0, bandwidth_ratio_field_q}
                                       + `INTERVAL_EXP_BASE;
  wire [3:0]             win_exp     = {2'h0, burst_time_field_q} + `WINDOW_EXP_BASE;
  wire [11:0]            int_mask    = (12'h001 << int_exp) - 12'h001;
  wire [11:0]            int_pos     = {1'b0, free_cnt_q} & int_mask;
  wire                   boundary    = (int_pos == int_mask);
  wire                   in_window   = (int_pos < (12'h001 << win_exp));
  wire [11:0]            busy_next   = busy_cnt_q + {11'h000, ~bus_grant_acknowledge_n_i};
  wire [1:0]             cur_src     = ctl_q[cur_q][`CTL_SRC_LSB+1:`CTL_SRC_LSB];
  wire [1:0]             cur_ext     = ctl_q[cur_q][`CTL_EXT_LSB+1:`CTL_EXT_LSB];
  wire [1:0]             cur_dtype   = ctl_q[cur_q][`CTL_DTYPE_LSB+1:`CTL_DTYPE_LSB];
  wire                   cur_dual    = ~cur_dtype[1];
  wire                   cur_auto    = ~cur_src[1];
  // Device side of a dual operand: read phase if device is source
  wire                   dev_phase   = ~chain_q & (~cur_dual | (phase_q == ctl_q[cur_q][`CTL_DIR_BIT]));
  wire                   quiet_ack   = cur_auto & (cur_dtype == `DTYPE_DUAL_16);
  wire                   ready_ok    = ~(dev_phase & (cur_dtype == `DTYPE_SINGLE_READY))
                                       | ~peripheral_control_line_n_i[cur_q];
  wire                   last_cycle  = chain_q | ~cur_dual | phase_q;

  // Priority pick with rotation among equal levels
  function [1:0] arbitrate;
    input [CHANNELS-1:0] w;
    input [1:0]          start;
    input [7:0]          prios;
    reg   [1:0]          idx;
    reg   [2:0]          best;
    integer              k;
    begin
      arbitrate = start;
      best      = 3'h4;
      for (k = 0; k < 4; k = k + 1) begin
        idx = start + k[1:0];
        if (w[idx] && ({1'b0, prios[idx*2 +: 2]} < best)) begin
          best      = {1'b0, prios[idx*2 +: 2]};
          arbitrate = idx;
        end
      end
    end
  endfunction

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One-cycle answer; write takes effect on the edge that sees ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_ack_o) begin
        if (wb_adr_i == `GENERAL_CONTROL_REGISTER_ADDR)
          wb_dat_o <= {28'h0000000, bandwidth_ratio_field_q, burst_time_field_q};
        else if (wb_adr_i == `STATUS_REGISTER_ADDR)
          wb_dat_o <= {21'h000000, hold_q, allow_q, bus_owned_o, pending_q, active_q};
        else if (wb_index[3:2] == 2'h1)
          wb_dat_o <= {21'h000000, ctl_q[wb_index[1:0]][10:1], active_q[wb_index[1:0]]};
        else if (wb_index[3:2] == 2'h2)
          wb_dat_o <= {{(32-COUNT_WIDTH){1'b0}}, count_q[wb_index[1:0]]};
      end
    end
  end

  // General control register
  always @(posedge clk_i) begin
    if (rst_i) begin
      burst_time_field_q      <= 2'h0;
      bandwidth_ratio_field_q <= 2'h0;
    end else if (wb_write && wb_sel_i[0] && wb_adr_i == `GENERAL_CONTROL_REGISTER_ADDR) begin
      burst_time_field_q      <= wb_dat_i[1:0];
      bandwidth_ratio_field_q <= wb_dat_i[3:2];
    end
  end

  // ****************************************
  // Sample interval and utilisation
  // ****************************************
  // Free-running counter shared by limited rate and hold pause
  always @(posedge clk_i) begin
    if (rst_i) begin
      free_cnt_q <= 11'h000;
      busy_cnt_q <= 12'h000;
      allow_q    <= 1'b1;
    end else begin
      free_cnt_q <= free_cnt_q + 11'h001;                              // R05 R07
      if (boundary) begin
        busy_cnt_q <= 12'h000;
        allow_q    <= (busy_next <= (12'h001 << win_exp));             // R08 R24
      end else begin
        busy_cnt_q <= busy_next;                                       // R09
      end
    end
  end

  // ****************************************
  // Per-channel request recognition
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      wire [1:0] src     = ctl_q[g][`CTL_SRC_LSB+1:`CTL_SRC_LSB];
      wire [1:0] ext     = ctl_q[g][`CTL_EXT_LSB+1:`CTL_EXT_LSB];
      wire       ctl_wr  = wb_write && (wb_index == (4'h4 + g)) && wb_sel_i[0];
      wire       cnt_wr  = wb_write && (wb_index == (4'h8 + g)) && wb_sel_i[0];
      wire       taken   = (state_q == ST_ADDR) && (cur_q == g) && !chain_q && !phase_q;
      wire       devgo   = (state_q == ST_ADDR) && (cur_q == g) && dev_phase;
      wire       op_done = (state_q == ST_END) && (cur_q == g) && last_cycle && !chain_q && !aborted_q;
      wire       last_op = op_done && (count_q[g] == {{(COUNT_WIDTH-1){1'b0}}, 1'b1});
      // Falling edge held low for two clocks
      wire       steal_edge = req_d2_q[g] & ~req_d1_q[g] & ~request_n_i[g];  // R15

      // Control and count
      always @(posedge clk_i) begin
        if (rst_i) begin
          ctl_q[g]   <= 11'h000;
          count_q[g] <= {COUNT_WIDTH{1'b0}};
        end else begin
          if (ctl_wr)
            ctl_q[g] <= wb_dat_i[10:0];
          if (cnt_wr)
            count_q[g] <= wb_dat_i[COUNT_WIDTH-1:0];
          else if (op_done)
            count_q[g] <= count_q[g] - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
      end

      // Activity, first auto request, pending steal edges
      always @(posedge clk_i) begin
        if (rst_i) begin
          active_q[g]  <= 1'b0;
          first_q[g]   <= 1'b0;
          pending_q[g] <= 1'b0;
          blocked_q[g] <= 1'b0;
          req_d1_q[g]  <= 1'b1;
          req_d2_q[g]  <= 1'b1;
        end else begin
          req_d1_q[g] <= request_n_i[g];
          req_d2_q[g] <= req_d1_q[g];
          if (ctl_wr) begin
            active_q[g] <= wb_dat_i[`CTL_START_BIT];
            first_q[g]  <= wb_dat_i[`CTL_START_BIT];                    // R03
          end else begin
            if (last_op)
              active_q[g] <= 1'b0;
            if (taken)
              first_q[g] <= 1'b0;
          end
          // Block edges between dual operand start and device transfer start
          if (devgo)
            blocked_q[g] <= 1'b0;                                      // R20
          else if (taken && cur_dual)
            blocked_q[g] <= 1'b1;                                      // R20
          // Edge set wins over the clear of a starting operand
          if (steal_edge && !blocked_q[g])
            pending_q[g] <= 1'b1;                                      // R15 R16
          else if (taken || ctl_wr)
            pending_q[g] <= 1'b0;
        end
      end

      // Request source per generation mode
      always @* begin
        case (src)
          `SRC_AUTO_LIMITED:  wants[g] = allow_q & in_window;         // R05 R06
          `SRC_AUTO_MAX:      wants[g] = 1'b1;                         // R04
          default: begin
            if (first_q[g] && src == `SRC_MIXED)
              wants[g] = 1'b1;                                         // R03
            else if (ext == `EXT_BURST)
              wants[g] = ~request_n_i[g];                              // R12 R13
            else
              wants[g] = pending_q[g];                                 // R12
          end
        endcase
        wants[g] = wants[g] & active_q[g] & ~last_op;
      end
    end
  endgenerate

  // Arbitration result
  always @* begin
    pick     = arbitrate(wants, rr_q, {ctl_q[3][8:7], ctl_q[2][8:7], ctl_q[1][8:7], ctl_q[0][8:7]});
    any_want = |wants;
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (any_want || chain_fetch_i) state_d = ST_ARB;
      ST_ARB:  if (!bus_grant_n_i) state_d = ST_ADDR;
      ST_ADDR: state_d = ST_WAIT;
      ST_WAIT: begin
        if (!bus_error_n_i)
          state_d = ST_END;                                            // R01
        else if (!dtack_n_i && ready_ok)
          state_d = ST_TCS;                                            // R21
      end
      ST_TCS:  state_d = ST_NEG;                                       // R02
      ST_NEG:  state_d = ST_END;                                       // R02
      ST_END: begin
        if (!last_cycle && !aborted_q)
          state_d = ST_ADDR;                                           // R22
        else if (chain_fetch_i || any_want)
          state_d = ST_ADDR;                                           // R16 R10
        else if (hold_q || cur_ext == `EXT_STEAL_HOLD)
          state_d = ST_HOLD;                                           // R17 R19
        else
          state_d = ST_IDLE;                                           // R17
      end
      ST_HOLD: begin
        if (chain_fetch_i || any_want)
          state_d = ST_ADDR;                                           // R18 R19
        else if (!hold_q)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State, current channel and holding register
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      cur_q     <= 2'h0;
      rr_q      <= 2'h0;
      phase_q   <= 1'b0;
      chain_q   <= 1'b0;
      aborted_q <= 1'b0;
      holding_q <= {DATA_WIDTH{1'b0}};
    end else begin
      state_q <= state_d;
      if (state_q == ST_WAIT && !bus_error_n_i)
        aborted_q <= 1'b1;
      else if (state_d == ST_ADDR && state_q != ST_ADDR)
        aborted_q <= 1'b0;
      // Dual operand: source read lands in holding register
      if (state_q == ST_WAIT && !dtack_n_i && read_not_write_o)
        holding_q <= bus_data_i;                                       // R22
      if (state_d == ST_ADDR) begin
        if (state_q == ST_END && !last_cycle && !aborted_q) begin
          phase_q <= 1'b1;                                             // R22
        end else begin
          phase_q <= 1'b0;
          chain_q <= chain_fetch_i;
          if (!chain_fetch_i) begin
            cur_q <= pick;                                             // R10
            rr_q  <= pick + 2'h1;                                      // R10
          end
        end
      end
    end
  end

  wire steal_any = ~request_n_i[cur_q];
  // Bus hold for cycle steal with hold
  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_q       <= 1'b0;
      hold_armed_q <= 1'b0;
      seen_q       <= 1'b0;
    end else begin
      if (state_q == ST_END && !chain_q && cur_ext == `EXT_STEAL_HOLD && cur_src[1]) begin
        hold_q       <= 1'b1;                                          // R17
        hold_armed_q <= 1'b0;
        seen_q       <= 1'b0;
      end else if (hold_q) begin
        if (!active_q[cur_q] && !ctl_q[cur_q][`CTL_START_BIT])
          hold_q <= 1'b0;                                              // R17 R19
        else if (boundary) begin
          // Pause: a full interval with no request releases the bus
          if (hold_armed_q && !seen_q && !pending_q[cur_q])
            hold_q <= 1'b0;                                            // R17
          hold_armed_q <= 1'b1;
          seen_q       <= 1'b0;
        end else if (pending_q[cur_q] || steal_any) begin
          seen_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Registered outputs; bus controls from the next state, acknowledges from the current state
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_request_n_o              <= 1'b1;
      bus_owned_o                  <= 1'b0;
      address_strobe_n_o           <= 1'b1;
      lower_data_strobe_n_o        <= 1'b1;
      upper_data_strobe_n_o        <= 1'b1;
      transfer_complete_strobe_n_o <= 1'b1;
      read_not_write_o             <= 1'b1;
      device_phase_o               <= 1'b0;
      ack_n_o                      <= {CHANNELS{1'b1}};
      high_byte_indicator_n_o      <= 1'b1;
      done_o                       <= 1'b0;
      done_oe_o                    <= 1'b0;
      channel_o                    <= 2'h0;
      bus_data_o                   <= {DATA_WIDTH{1'b0}};
    end else begin
      bus_request_n_o    <= ~(state_d == ST_ARB);
      bus_owned_o        <= (state_d != ST_IDLE) && (state_d != ST_ARB);
      address_strobe_n_o <= ~((state_d == ST_ADDR) || (state_d == ST_WAIT) || (state_d == ST_TCS));
      // Data strobes span wait and strobe states, drop one state before the strobe rises
      lower_data_strobe_n_o        <= ~((state_d == ST_WAIT) || (state_d == ST_TCS));
      upper_data_strobe_n_o        <= ~((state_d == ST_WAIT) || (state_d == ST_TCS));
      // Strobe low only on completed transfers and chain fetches, not after an exception
      transfer_complete_strobe_n_o <= ~((state_d == ST_TCS) || (state_d == ST_NEG));  // R01 R02
      channel_o                    <= cur_q;
      device_phase_o               <= dev_phase;
      bus_data_o                   <= holding_q;
      read_not_write_o             <= chain_q | ~phase_q;
      if (state_d == ST_ADDR && state_q == ST_END && !last_cycle)
        read_not_write_o <= 1'b0;
      // Acknowledge selects the device implicitly while its cycle runs
      if ((state_q == ST_ADDR || state_q == ST_WAIT || state_q == ST_TCS) && dev_phase && !quiet_ack) begin
        ack_n_o                 <= ~(4'h1 << cur_q);                   // R23 R21
        high_byte_indicator_n_o <= ~ctl_q[cur_q][`CTL_HBYTE_BIT];
        done_oe_o               <= (count_q[cur_q] == {{(COUNT_WIDTH-1){1'b0}}, 1'b1});
      end else begin
        ack_n_o                 <= {CHANNELS{1'b1}};                   // R11
        high_byte_indicator_n_o <= 1'b1;                               // R11
        done_oe_o               <= 1'b0;                               // R11
      end
      done_o <= 1'b0;
    end
  end

endmodule // dma_request_recognition

// *** bench/dma_request_recognition_properties.sv ***
// Port checker for the DMA request recognition block
`timescale 1ns/1ps
module dma_request_recognition_properties (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_i,
  // Watched ports
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  input wire [3:0] ack_n_o,
  input wire       bus_owned_o,
  input wire       dtack_n_i,
  input wire       bus_error_n_i,
  input wire       transfer_complete_strobe_n_o,
  input wire       lower_data_strobe_n_o
);
  wire tcs = transfer_complete_strobe_n_o;
  wire dsn = lower_data_strobe_n_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Strobe leads and trails the data strobe rise by one cycle
  sequence strobe_tail_s;
    !dsn ##1 (dsn && !tcs) ##1 tcs;
  endsequence
  chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  chk_wb_quiet: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("bus ack without request");
  chk_strobe_order: assert property ($fell(tcs) |-> strobe_tail_s)
    else $error("transfer strobe misaligned");
  chk_strobe_cause: assert property ($fell(tcs) |-> $past(!dtack_n_i))
    else $error("transfer strobe without memory ack");
  chk_error_silent: assert property (!bus_error_n_i && dtack_n_i && !dsn |=> tcs [*2])
    else $error("transfer strobe after bus error");
  chk_owned_release: assert property ($fell(bus_owned_o) |-> tcs && dsn)
    else $error("bus released mid cycle");
  chk_strobe_owned: assert property (!tcs |-> bus_owned_o)
    else $error("transfer strobe without bus");
  chk_ack_owned: assert property (!(&ack_n_o) |-> bus_owned_o)
    else $error("acknowledge without bus");
endmodule // dma_request_recognition_properties

bind dma_request_recognition dma_request_recognition_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ack_n_o(ack_n_o), .bus_owned_o(bus_owned_o),
  .dtack_n_i(dtack_n_i), .bus_error_n_i(bus_error_n_i), .transfer_complete_strobe_n_o(transfer_complete_strobe_n_o),
  .lower_data_strobe_n_o(lower_data_strobe_n_o));

// *** bench/bus_side_model.sv ***
// Memory and arbiter model on the system bus side
`timescale 1ns/1ps
module bus_side_model (
  // Clock, reset and modes
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire        fault_i,
  // Bus lines
  input  wire        bus_request_n_i,
  input  wire        bus_owned_i,
  input  wire        data_strobe_n_i,
  output reg         grant_n_o,
  output wire        grant_ack_n_o,
  output reg         dtack_n_o,
  output reg         bus_error_n_o,
  output reg  [15:0] data_o
);
  reg [1:0] wait_q;
  assign grant_ack_n_o = !bus_owned_i;
  // Grant a cycle after request; answer after optional wait states
  always @(posedge clk_i) begin
    wait_q        <= data_strobe_n_i ? 2'h0 : wait_q + {1'b0, wait_q != 2'h3};
    grant_n_o     <= rst_i | bus_request_n_i;
    dtack_n_o     <= data_strobe_n_i | fault_i | (slow_i & (wait_q != 2'h3));
    bus_error_n_o <= data_strobe_n_i | !fault_i;
    data_o        <= rst_i ? 16'hA5C3 : ~data_o;
  end
endmodule // bus_side_model

// *** bench/tb.sv ***
// Self-checking testbench for the DMA request recognition block
`timescale 1ns/1ps
module tb;
  reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slow = 0, fault = 0;
  reg  [5:0]  adr = 6'h00;
  reg  [31:0] dat = 32'h0;
  reg  [3:0]  req_n = 4'hF;
  wire [31:0] rdat;
  wire [15:0] bdat;
  wire [3:0]  ack_n;
  wire        ack, tcs, dsn, breq_n, owned, gnt_n, gack_n, dtack_n, berr_n;
  int         mismatches = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  dma_request_recognition u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .request_n_i(req_n),
    .peripheral_control_line_n_i(4'hF), .ack_n_o(ack_n), .high_byte_indicator_n_o(), .done_o(), .done_oe_o(),
    .transfer_complete_strobe_n_o(tcs), .bus_grant_n_i(gnt_n), .bus_grant_acknowledge_n_i(gack_n),
    .dtack_n_i(dtack_n), .bus_error_n_i(berr_n), .chain_fetch_i(1'b0), .bus_data_i(bdat), .bus_data_o(),
    .bus_request_n_o(breq_n), .bus_owned_o(owned), .address_strobe_n_o(), .lower_data_strobe_n_o(dsn),
    .upper_data_strobe_n_o(), .read_not_write_o(), .device_phase_o(), .channel_o());
  bus_side_model u_bus (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .fault_i(fault), .bus_request_n_i(breq_n),
    .bus_owned_i(owned), .data_strobe_n_i(dsn), .grant_n_o(gnt_n), .grant_ack_n_o(gack_n),
    .dtack_n_o(dtack_n), .bus_error_n_o(berr_n), .data_o(bdat));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single bus cycle, held until ack
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  // Start a channel for two transfers, count strobes and flag any ack
  task automatic run(input int ch, input logic [31:0] ctl, input int low, output int n, output logic hit);
    logic [31:0] q;
    logic        p;
    wb(1, 6'h20 + 6'(4 * ch), 32'h2, q);
    wb(1, 6'h10 + 6'(4 * ch), ctl, q);
    n = 0;
    hit = 0;
    p = 1;
    req_n[ch] <= (low == 0);
    repeat (300) begin
      @(posedge clk_i);
      if (--low == 0) req_n[ch] <= 1;
      if (tcs === 1'b0 && p) n++;
      p = tcs;
      hit |= (ack_n[ch] === 1'b0);
    end
  endtask
  task automatic t_regs;
    logic [31:0] q;
    wb(1, 6'h00, 32'h0000000F, q);
    wb(0, 6'h00, 32'h0, q);
    chk(q, 32'h0000000F);
    wb(0, 6'h3C, 32'h0, q);
    chk(q, 32'h0);
    wb(1, 6'h00, 32'h0, q);
    $display("registers done");
  endtask
  task automatic t_modes;
    int n;
    logic h;
    run(0, 32'h45, 300, n, h);
    chk(32'(n), 32'h2);
    chk({31'h0, h}, 32'h1);
    run(1, 32'h03, 0, n, h);
    chk(32'(n), 32'h4);
    chk({31'h0, h}, 32'h0);
    slow <= 1;
    run(3, 32'h55, 40, n, h);
    chk(32'(n), 32'h1);
    slow <= 0;
    fault <= 1;
    run(2, 32'h45, 100, n, h);
    chk(32'(n), 32'h0);
    fault <= 0;
    $display("request modes done");
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_modes;
    final_report;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    final_report;
  end
endmodule // tb
